// [rtl/adcseq_cfg.svh]
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH
`define ADCSEQ_OFS_CTRL 32'h0000_0000
`define ADCSEQ_OFS_SEL 32'h0000_0004
`define ADCSEQ_OFS_STAT 32'h0000_0008
`define ADCSEQ_CTRL_START 0
`define ADCSEQ_CTRL_ENABLE 1
`define ADCSEQ_CTRL_AUTO 2
`define ADCSEQ_CTRL_DONE 3
`define ADCSEQ_CTRL_FREE 4
`define ADCSEQ_CTRL_PS_LSB 8
`define ADCSEQ_SEL_REF_LSB 5
`define ADCSEQ_FIRST_CONV_CYC 25
`define ADCSEQ_NORM_CONV_CYC 13
`define ADCSEQ_FIRST_SH_CYC 13
`define ADCSEQ_NORM_SH_CYC 1
`define ADCSEQ_AUTO_SH_CYC 2
`define ADCSEQ_PS_DEFAULT 8'h03
`endif

// [rtl/adcseq_pkg.sv]
package adcseq_pkg;
  typedef enum logic [1:0] {
    ADCSEQ_IDLE,
    ADCSEQ_CONV
  } adcseq_state_t;
  typedef struct packed {
    adcseq_state_t st;
    logic enable;
    logic auto_en;
    logic free_run;
    logic start_bit;
    logic start_pend;
    logic done_flag;
    logic first;
    logic [7:0] ps_div;
    logic [7:0] ps_cnt;
    logic [4:0] conv_cnt;
    logic [4:0] chan_shadow;
    logic [1:0] ref_shadow;
    logic [4:0] chan_work;
    logic [1:0] ref_work;
    logic sample;
    logic trig_s1;
    logic trig_s2;
    logic trig_d;
    logic sleep_s1;
    logic sleep_s2;
    logic sleep_d;
    logic irq_pend;
    logic hsel_d;
    logic hwrite_d;
    logic [3:0] haddr_d;
    logic [31:0] hrdata;
  } adcseq_regs_t;
endpackage

// [rtl/adcseq_top.sv]
// Overview of operation
// - First conversion samples at 13.5 and lasts 25 clocks; normal 1.5 and 13.
// - Shadow selection writable any time; working copy tracks it while idle.
// - Working selection frozen while a conversion runs.
// - Tracking resumes in the final converter clock before the done flag.
// - A start write begins conversion at the next converter clock edge.
// - Selection writes in safe windows apply from the following conversion.
// - Free running restarts at completion; late selection applies one later.
// - Entering idle or noise-reduction sleep launches a conversion.
// - A sleep-started conversion completes and raises its request despite wakeup.
// - Other sleep states leave the converter enable untouched.
// - Auto trigger edge resets the prescaler; sample two clocks later.
// - Start bit reads one while converting, except in a conversion queued by a start write mid-conversion; clears at completion unless free running.
// - Prescaler held in reset while disabled, except for the first cycle when disabled on an auto trigger edge; free counting once enabled.
// - Trigger rising edge starts a conversion; edges during conversion ignored.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_cfg.svh"
module adcseq_top
  import adcseq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic trigger_in,
  input wire logic sleep_quiet,
  output logic [4:0] channel_select,
  output logic [1:0] reference_select,
  output logic sample_hold,
  output logic conversion_done_irq
);
  import adcseq_pkg::*;
  adcseq_regs_t r_reg;
  adcseq_regs_t r_next;
  logic adc_tick;
  logic trig_edge;
  logic sleep_edge;
  logic wr_en;
  logic last_cyc;
  logic [4:0] conv_len;
  logic [4:0] sh_at;
  logic go;

  assign adc_tick = r_reg.enable && (r_reg.ps_cnt == r_reg.ps_div);
  assign trig_edge = r_reg.trig_s2 && !r_reg.trig_d;
  assign sleep_edge = r_reg.sleep_s2 && !r_reg.sleep_d;
  assign wr_en = r_reg.hsel_d && r_reg.hwrite_d;
  assign conv_len = r_reg.first ? 5'(`ADCSEQ_FIRST_CONV_CYC) : 5'(`ADCSEQ_NORM_CONV_CYC);
  assign sh_at = r_reg.first ? 5'(`ADCSEQ_FIRST_SH_CYC) : 5'(`ADCSEQ_NORM_SH_CYC);
  assign last_cyc = (r_reg.st == ADCSEQ_CONV) && (r_reg.conv_cnt == conv_len - 5'h01);
  assign go = adc_tick && r_reg.start_pend && (r_reg.st == ADCSEQ_IDLE);

  always_comb
  begin
    r_next = r_reg;
    r_next.trig_s1 = trigger_in;
    r_next.trig_s2 = r_reg.trig_s1;
    r_next.trig_d = r_reg.trig_s2;
    r_next.sleep_s1 = sleep_quiet;
    r_next.sleep_s2 = r_reg.sleep_s1;
    r_next.sleep_d = r_reg.sleep_s2;
    r_next.hsel_d = hsel && hready && htrans[1];
    r_next.hwrite_d = hwrite;
    r_next.haddr_d = haddr[3:0];
    r_next.sample = 1'b0;
    r_next.irq_pend = 1'b0;
    if (wr_en)
    begin
      case (r_reg.haddr_d)
        4'h0:
        begin
          r_next.enable = hwdata[`ADCSEQ_CTRL_ENABLE];
          r_next.auto_en = hwdata[`ADCSEQ_CTRL_AUTO];
          r_next.free_run = hwdata[`ADCSEQ_CTRL_FREE];
          r_next.ps_div = hwdata[`ADCSEQ_CTRL_PS_LSB +: 8];
          if (hwdata[`ADCSEQ_CTRL_START] && hwdata[`ADCSEQ_CTRL_ENABLE])
          begin
            r_next.start_pend = 1'b1;
            r_next.start_bit = 1'b1;
          end
          if (hwdata[`ADCSEQ_CTRL_DONE])
            r_next.done_flag = 1'b0;
          if (!r_reg.enable && hwdata[`ADCSEQ_CTRL_ENABLE])
            r_next.first = 1'b1;
        end
        4'h4:
        begin
          r_next.chan_shadow = hwdata[4:0];
          r_next.ref_shadow = hwdata[`ADCSEQ_SEL_REF_LSB +: 2];
        end
        default:
        begin
        end
      endcase
    end
    if (r_reg.enable && sleep_edge && r_reg.st == ADCSEQ_IDLE)
    begin
      r_next.start_pend = 1'b1;
      r_next.start_bit = 1'b1;
    end
    if (r_reg.enable && r_reg.auto_en && trig_edge && r_reg.st == ADCSEQ_IDLE)
    begin
      r_next.start_pend = 1'b1;
      r_next.start_bit = 1'b1;
      r_next.ps_cnt = r_reg.ps_div;
    end
    else if (!r_next.enable)
      r_next.ps_cnt = 8'h00;
    else if (adc_tick)
      r_next.ps_cnt = 8'h00;
    else
      r_next.ps_cnt = r_reg.ps_cnt + 8'h01;
    if (r_reg.st == ADCSEQ_IDLE || last_cyc)
    begin
      r_next.chan_work = r_reg.chan_shadow;
      r_next.ref_work = r_reg.ref_shadow;
    end
    case (r_reg.st)
      ADCSEQ_IDLE:
      begin
        if (go)
        begin
          r_next.st = ADCSEQ_CONV;
          r_next.start_pend = 1'b0;
          r_next.conv_cnt = 5'h00;
        end
      end
      ADCSEQ_CONV:
      begin
        if (adc_tick)
        begin
          r_next.conv_cnt = r_reg.conv_cnt + 5'h01;
          if (r_reg.conv_cnt == sh_at)
            r_next.sample = 1'b1;
          if (last_cyc)
          begin
            r_next.done_flag = 1'b1;
            r_next.irq_pend = 1'b1;
            r_next.first = 1'b0;
            r_next.conv_cnt = 5'h00;
            if (r_reg.free_run)
              r_next.st = ADCSEQ_CONV;
            else
            begin
              r_next.st = ADCSEQ_IDLE;
              r_next.start_bit = 1'b0;
            end
          end
        end
      end
      default:
        r_next.st = ADCSEQ_IDLE;
    endcase
    if (!r_next.enable)
    begin
      r_next.st = ADCSEQ_IDLE;
      r_next.start_bit = 1'b0;
      r_next.start_pend = 1'b0;
    end
    case (haddr[3:0])
      4'h0: r_next.hrdata = {16'h0000, r_next.ps_div, 3'h0, r_next.free_run,
        r_next.done_flag, r_next.auto_en, r_next.enable, r_next.start_bit};
      4'h4: r_next.hrdata = {25'h0000000, r_next.ref_shadow, r_next.chan_shadow};
      4'h8: r_next.hrdata = {20'h00000, 3'h0, r_next.conv_cnt, 2'h0, r_next.first,
        r_reg.st == ADCSEQ_CONV};
      default: r_next.hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_reg <= '0;
      r_reg.ps_div <= `ADCSEQ_PS_DEFAULT;
    end
    else
      r_reg <= r_next;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign channel_select = r_reg.chan_work;
  assign reference_select = r_reg.ref_work;
  assign sample_hold = r_reg.sample;
  assign conversion_done_irq = r_reg.irq_pend;

  property p_freeze;
    @(posedge clk_sys) disable iff (!arst_n)
    (r_reg.st == ADCSEQ_CONV && !last_cyc) |=> $stable(r_reg.chan_work);
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection changed mid conversion");
  property p_track;
    @(posedge clk_sys) disable iff (!arst_n)
    (r_reg.st == ADCSEQ_IDLE) |=> (r_reg.chan_work == $past(r_reg.chan_shadow));
  endproperty
  a_track: assert property (p_track) else $error("idle selection not tracking");
  property p_done_clears_start;
    @(posedge clk_sys) disable iff (!arst_n)
    (last_cyc && adc_tick && !r_reg.free_run && r_next.enable) |=> (!r_reg.start_bit && r_reg.done_flag);
  endproperty
  a_done_clears_start: assert property (p_done_clears_start) else $error("start not cleared");
  property p_busy_start;
    @(posedge clk_sys) disable iff (!arst_n)
    (r_reg.st == ADCSEQ_CONV) |-> r_reg.start_bit || r_reg.free_run;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start low while busy");
  property p_ps_reset;
    @(posedge clk_sys) disable iff (!arst_n)
    !r_reg.enable |-> (r_reg.ps_cnt == 8'h00);
  endproperty
  a_ps_reset: assert property (p_ps_reset) else $error("prescaler ran while disabled");
  property p_start_on_tick;
    @(posedge clk_sys) disable iff (!arst_n)
    (r_reg.st == ADCSEQ_IDLE && r_next.st == ADCSEQ_CONV) |-> adc_tick;
  endproperty
  a_start_on_tick: assert property (p_start_on_tick) else $error("start off clock edge");
  property p_irq_done;
    @(posedge clk_sys) disable iff (!arst_n)
    conversion_done_irq |-> r_reg.done_flag;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("irq without done");
  property p_ignore_trig;
    @(posedge clk_sys) disable iff (!arst_n)
    (r_reg.st == ADCSEQ_CONV && trig_edge && !last_cyc) |=> (r_reg.st == ADCSEQ_CONV || !r_reg.enable);
  endproperty
  a_ignore_trig: assert property (p_ignore_trig) else $error("trigger broke conversion");
  c_conv: cover property (@(posedge clk_sys) disable iff (!arst_n) conversion_done_irq);
  c_sample: cover property (@(posedge clk_sys) disable iff (!arst_n) sample_hold);
  c_sleep: cover property (@(posedge clk_sys) disable iff (!arst_n) sleep_edge && r_reg.enable);
endmodule
`default_nettype wire

// [sim/adcseq_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcseq_core_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sleep_cmd,
  input wire logic other_irq,
  input wire logic conversion_done_irq,
  output logic sleep_quiet,
  output int wake_count
);
  // Halts on command alone, whatever state the converter is in
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_quiet <= 1'b0;
      wake_count <= 0;
    end
    else if (sleep_cmd && !sleep_quiet)
      sleep_quiet <= 1'b1;
    else if (sleep_quiet && (other_irq || conversion_done_irq))
    begin
      sleep_quiet <= 1'b0;
      wake_count <= wake_count + 1;
    end
  end
endmodule
`default_nettype wire

// [sim/test_adc_conversion_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_cfg.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module test_adc_conversion_sequencer;
  localparam int T = 4;
  localparam logic [31:0] CT = `ADCSEQ_OFS_CTRL;
  localparam logic [31:0] SL = `ADCSEQ_OFS_SEL;
  logic clk_sys = 0, arst_n = 0, hsel = 0, hwrite = 0;
  logic trigger_in = 0, sleep_cmd = 0, other_irq = 0;
  logic [31:0] haddr = 0, hwdata = 0, q, s_old, s_new;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire logic hreadyout, hresp, sample_hold, conversion_done_irq, sleep_quiet;
  wire logic [31:0] hrdata;
  wire logic [4:0] channel_select;
  wire logic [1:0] reference_select;
  wire logic [6:0] wsel = {reference_select, channel_select};
  int wake_count;
  int fails = 0, check_count = 0, seed = 39, cyc = 0;
  int nirq = 0, tirq = 0, gap = 0, tsh = 0, t0, k, n0;
  adcseq_top dut (.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .trigger_in,
    .sleep_quiet, .channel_select, .reference_select, .sample_hold,
    .conversion_done_irq);
  adcseq_core_model core (.clk_sys, .arst_n, .sleep_cmd, .other_irq,
    .conversion_done_irq, .sleep_quiet, .wake_count);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (conversion_done_irq === 1'b1)
    begin
      nirq <= nirq + 1;
      gap <= cyc - tirq;
      tirq <= cyc;
    end
    if (sample_hold === 1'b1)
      tsh <= cyc;
  end
  task automatic results();
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      results();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wirq(input int lim);
    int n;
    n = nirq;
    k = 0;
    while (nirq == n && k < lim)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= lim)
    begin
      fails++;
      results();
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    ahb(0, CT, 0);
    `CHK("ctrl rst", 32'(`ADCSEQ_PS_DEFAULT) << `ADCSEQ_CTRL_PS_LSB, q)
    `CHK("hresp", 1'b0, hresp)
    ahb(0, 32'h0000_000C, 0);
    `CHK("unmapped", 32'h0, q)
    ahb(1, CT, 32'h0302);
    repeat (3)
    begin
      s_new = $random(seed) & 32'h7F;
      ahb(1, SL, s_new);
      repeat (2) @(posedge clk_sys);
      `CHK("track", s_new[6:0], wsel)
    end
    s_old = s_new;
    ahb(1, CT, 32'h0303);
    t0 = cyc;
    repeat (2 * T) @(posedge clk_sys);
    s_new = $random(seed) & 32'h7F;
    ahb(1, SL, s_new);
    ahb(0, CT, 0);
    `CHK("busy", 1'b1, q[0])
    ahb(0, `ADCSEQ_OFS_STAT, 0);
    `CHK("stat busy", 1'b1, q[0])
    `CHK("frozen", s_old[6:0], wsel)
    wirq(40 * T);
    `CHK("first", 1'b1, tirq - t0 >= 25 * T - 2 && tirq - t0 <= 26 * T + 4)
    `CHK("sh", 1'b1, tirq - tsh >= 11 * T && tirq - tsh <= 13 * T)
    `CHK("resume", s_new[6:0], wsel)
    ahb(0, CT, 0);
    `CHK("done", 16'h030A, q[15:0])
    ahb(1, CT, 32'h030A);
    ahb(0, CT, 0);
    `CHK("clr", 16'h0302, q[15:0])
    ahb(1, CT, 32'h0313);
    wirq(20 * T);
    wirq(20 * T);
    `CHK("gap", 13 * T, gap)
    s_old = s_new;
    s_new = ~s_old & 32'h7F;
    ahb(1, SL, s_new);
    `CHK("late", s_old[6:0], wsel)
    ahb(1, CT, 32'h030A);
    wirq(20 * T);
    `CHK("next", s_new[6:0], wsel)
    ahb(1, CT, 32'h030E);
    repeat (2 + ($unsigned($random(seed)) % T)) @(posedge clk_sys);
    n0 = nirq;
    trigger_in <= 1'b1;
    t0 = cyc;
    repeat (T) @(posedge clk_sys);
    trigger_in <= 1'b0;
    repeat (2 * T) @(posedge clk_sys);
    trigger_in <= 1'b1;
    repeat (T) @(posedge clk_sys);
    trigger_in <= 1'b0;
    wirq(20 * T);
    `CHK("auto sh", 1'b1, tsh - t0 >= 2 * T && tsh - t0 <= 2 * T + 6)
    repeat (20 * T) @(posedge clk_sys);
    `CHK("ignored", n0 + 1, nirq)
    ahb(1, CT, 32'h030A);
    t0 = cyc;
    sleep_cmd <= 1'b1;
    @(posedge clk_sys);
    sleep_cmd <= 1'b0;
    repeat (3 * T) @(posedge clk_sys);
    other_irq <= 1'b1;
    @(posedge clk_sys);
    other_irq <= 1'b0;
    @(posedge clk_sys);
    `CHK("woke", 1, wake_count)
    wirq(20 * T);
    `CHK("launch", 1'b1, tsh > t0 && tirq - t0 <= 15 * T + 6)
    results();
  end
endmodule
`default_nettype wire
